// [rmx_consts.svh]
// offsets, reset values and event bit positions for the mask/flag block
`ifndef RMX_CONSTS_SVH
`define RMX_CONSTS_SVH
`define RMX_ADDR_W 12
`define RMX_OFF_MASK_LO 12'h00E
`define RMX_OFF_MASK_HI 12'h00F
`define RMX_OFF_PEND_LO 12'h010
`define RMX_OFF_PEND_MID 12'h011
`define RMX_OFF_PEND_HI 12'h012
`define RMX_MASK_RST 16'h0000
`define RMX_BYTE_RST 8'h00
`define RMX_PEND_RST 24'h000000
`define RMX_PEND_VALID 24'h7FFFFF
`define RMX_EV_RADIO_QUIET 0
`define RMX_EV_SEND_FRAME_FINISHED 1
`define RMX_EV_SEND_ACK_FINISHED 2
`define RMX_EV_RECEIVER_MASK_CLEARED 7
`define RMX_EV_UNUSED 23
`endif

// [rmx_pkg.sv]
// types for the mask/flag block
package rmx_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_ACK} rmx_state_t;
endpackage : rmx_pkg

// [rmx_flag_byte.sv]
// one byte of sticky pending bits, write zero to clear
`timescale 1ns/1ns
module rmx_flag_byte #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] set_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] flags_o
);
  logic [W-1:0] flags_q;

  // a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flags_q <= '0;
    end else if (wr_i) begin
      flags_q <= (flags_q & wdata_i) | set_i;
    end else begin
      flags_q <= flags_q | set_i;
    end
  end

  assign flags_o = flags_q;
endmodule : rmx_flag_byte

// [rmx_top.sv]
// receive-enable mask and sticky exception pending bits
`timescale 1ns/1ns
`include "rmx_consts.svh"
module rmx_top
  import rmx_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic [`RMX_ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [23:0] EVENT_I,
  input wire logic TX_START_I,
  input wire logic ACK_START_I,
  output logic RX_ON_O,
  output logic [15:0] RX_MASK_O,
  output logic [23:0] PENDING_O
);
  function automatic logic addr_hit(
    input logic [`RMX_ADDR_W-1:0] addr,
    input logic [`RMX_ADDR_W-1:0] off
  );
    addr_hit = (addr == off);
  endfunction : addr_hit

  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [23:0] pend;
  logic [23:0] pend_set;
  logic [7:0] rdata_q;
  logic mask_cleared;
  rmx_state_t state_q;
  logic wr_lo;
  logic wr_hi;

  assign wr_lo = REG_WR_I && addr_hit(REG_ADDR_I, `RMX_OFF_MASK_LO);
  assign wr_hi = REG_WR_I && addr_hit(REG_ADDR_I, `RMX_OFF_MASK_HI);

  // receive-enable mask, both bytes host writable
  always_comb begin
    mask_d = mask_q;
    if (wr_lo) begin
      mask_d[7:0] = REG_WDATA_I;
    end
    if (wr_hi) begin
      mask_d[15:8] = REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      mask_q <= `RMX_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign mask_cleared = (mask_q != 16'h0000) && (mask_d == 16'h0000);

  // event sources; bit 7 also raised by the mask reaching zero
  always_comb begin
    pend_set = EVENT_I & `RMX_PEND_VALID;
    pend_set[`RMX_EV_RECEIVER_MASK_CLEARED] =
      EVENT_I[`RMX_EV_RECEIVER_MASK_CLEARED] | mask_cleared;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pend
      rmx_flag_byte #(.W(8)) u_byte (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .set_i(pend_set[g*8 +: 8]),
        .wr_i(REG_WR_I &&
          addr_hit(REG_ADDR_I,
            `RMX_OFF_PEND_LO + `RMX_ADDR_W'(g))),
        .wdata_i(REG_WDATA_I),
        .flags_o(pend[g*8 +: 8])
      );
    end
  endgenerate

  // registered read port, unmapped reads zero
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      rdata_q <= `RMX_BYTE_RST;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `RMX_OFF_MASK_LO: rdata_q <= mask_q[7:0];
        `RMX_OFF_MASK_HI: rdata_q <= mask_q[15:8];
        `RMX_OFF_PEND_LO: rdata_q <= pend[7:0];
        `RMX_OFF_PEND_MID: rdata_q <= pend[15:8];
        `RMX_OFF_PEND_HI: rdata_q <= pend[23:16];
        default: rdata_q <= `RMX_BYTE_RST;
      endcase
    end
  end

  // main radio sequencing
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (TX_START_I) begin
            state_q <= ST_TX;
          end else if (ACK_START_I) begin
            state_q <= ST_ACK;
          end else if (mask_q != 16'h0000) begin
            state_q <= ST_RX;
          end
        end
        ST_RX: begin
          if (TX_START_I) begin
            state_q <= ST_TX;
          end else if (ACK_START_I) begin
            state_q <= ST_ACK;
          end else if (mask_q == 16'h0000) begin
            state_q <= ST_IDLE;
          end
        end
        ST_TX: begin
          if (EVENT_I[`RMX_EV_SEND_FRAME_FINISHED]) begin
            state_q <= (mask_q != 16'h0000) ? ST_RX : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (EVENT_I[`RMX_EV_SEND_ACK_FINISHED]) begin
            state_q <= (mask_q != 16'h0000) ? ST_RX : ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign RX_ON_O = (state_q == ST_RX);
  assign RX_MASK_O = mask_q;
  assign PENDING_O = pend;
  assign REG_RDATA_O = rdata_q;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  chk_mask_high_write: assert property (
    wr_hi |=> RX_MASK_O[15:8] == $past(REG_WDATA_I))
    else $error("mask high byte not written");

  chk_rx_from_idle: assert property (
    (state_q == ST_IDLE && !TX_START_I && !ACK_START_I &&
     mask_q != 16'h0000) |=> RX_ON_O)
    else $error("receiver not enabled from idle");

  chk_rx_after_send: assert property (
    (((state_q == ST_TX && EVENT_I[`RMX_EV_SEND_FRAME_FINISHED]) ||
      (state_q == ST_ACK && EVENT_I[`RMX_EV_SEND_ACK_FINISHED])) &&
     mask_q != 16'h0000) |=> RX_ON_O)
    else $error("receiver not enabled after send");

  chk_rx_to_idle: assert property (
    (state_q == ST_RX && !TX_START_I && !ACK_START_I &&
     mask_q == 16'h0000) |=> !RX_ON_O)
    else $error("receiver stayed on with empty mask");

  chk_event_sets: assert property (
    |EVENT_I |=> ((PENDING_O & $past(EVENT_I) & `RMX_PEND_VALID) ==
      ($past(EVENT_I) & `RMX_PEND_VALID)))
    else $error("event did not set pending bit");

  chk_unused_zero: assert property (
    !PENDING_O[`RMX_EV_UNUSED])
    else $error("unused pending bit set");

  chk_no_hw_clear: assert property (
    !REG_WR_I |=> (($past(PENDING_O) & ~PENDING_O) == 24'h000000))
    else $error("pending bit dropped without write");

  chk_zero_clears: assert property (
    (REG_WR_I && REG_ADDR_I == `RMX_OFF_PEND_MID &&
     REG_WDATA_I == 8'h00 && EVENT_I[15:8] == 8'h00)
    |=> PENDING_O[15:8] == 8'h00)
    else $error("zero write did not clear");

  chk_set_wins: assert property (
    (REG_WR_I && REG_ADDR_I == `RMX_OFF_PEND_LO &&
     REG_WDATA_I == 8'h00 && EVENT_I[`RMX_EV_RADIO_QUIET])
    |=> PENDING_O[`RMX_EV_RADIO_QUIET])
    else $error("event lost against clear");

  chk_pend_read: assert property (
    (REG_RD_I && REG_ADDR_I == `RMX_OFF_PEND_HI)
    |=> REG_RDATA_O == $past(PENDING_O[23:16]))
    else $error("pending read mismatch");

  chk_mask_read: assert property (
    (REG_RD_I && REG_ADDR_I == `RMX_OFF_MASK_HI)
    |=> REG_RDATA_O == $past(RX_MASK_O[15:8]))
    else $error("mask high read mismatch");

  chk_reset_clear: assert property (disable iff (1'b0)
    !NRST_I |=> (RX_MASK_O == `RMX_MASK_RST &&
      PENDING_O == `RMX_PEND_RST))
    else $error("reset did not clear registers");

  cov_mask_write: cover property (wr_hi ##1 RX_ON_O [*2]);
  cov_ack_to_rx: cover property (state_q == ST_ACK ##1 RX_ON_O);
  cov_flag_cleared: cover property (
    PENDING_O[0] ##1 !PENDING_O[0]);
  cov_tx_to_rx: cover property (state_q == ST_TX ##1 RX_ON_O);
  cov_set_on_clear: cover property (
    REG_WR_I && EVENT_I[`RMX_EV_RADIO_QUIET]
    ##1 PENDING_O[`RMX_EV_RADIO_QUIET]);
endmodule : rmx_top

// [rmx_host.sv]
// host model driving the register port
`timescale 1ns/1ns
`include "rmx_consts.svh"
module rmx_host (
  input wire logic clk_i,
  output logic [`RMX_ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 12'h000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // zero bits clear pending flags, one bits leave them
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : rmx_host

// [test_rx_mask_and_exception_flags.sv]
// random and corner tests of the mask and pending flag block
`timescale 1ns/1ns
module test_rx_mask_and_exception_flags;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] addr;
  logic wr;
  logic rd;
  logic [1:0] st = 2'b00;
  logic [7:0] wd;
  logic [7:0] rdat;
  logic [7:0] b;
  logic [23:0] ev_in = 24'h000000;
  logic [23:0] exp_p = 24'h000000;
  logic [23:0] e;
  logic [15:0] mask;
  logic rx_on;
  logic [23:0] pend;
  int k;
  int n_fail = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  rmx_top rmx_top_inst (.CLK_SYS_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
    .EVENT_I(ev_in), .TX_START_I(st[0]), .ACK_START_I(st[1]),
    .RX_ON_O(rx_on), .RX_MASK_O(mask), .PENDING_O(pend));
  rmx_host rmx_host_inst (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wd), .rdata_i(rdat));
  function automatic logic [23:0] set_p(input logic [23:0] p,
    input logic [23:0] v);
    return (p | v) & 24'h7FFFFF;
  endfunction : set_p
  function automatic logic [23:0] clr_p(input logic [23:0] p, input int n,
    input logic [7:0] d);
    return p & ~({16'h0000, ~d} << (8 * n));
  endfunction : clr_p
  task automatic cmp(input string n, input logic [23:0] x,
    input logic [23:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : cmp
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(input logic [23:0] v);
    step;
    ev_in = v;
    step;
    ev_in = 24'h000000;
  endtask : pulse
  task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
    logic [7:0] d;
    rmx_host_inst.rd(a, d);
    cmp("rdata", {16'h0000, x}, {16'h0000, d});
  endtask : rdchk
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #50000;
    n_fail++;
    final_report;
  end
  initial begin
    void'($urandom(59770));
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int a = 14; a <= 19; a++) rdchk(12'(a), 8'h00);
    $display("test reset done");
    rmx_host_inst.wr(12'h00F, 8'h80);
    cmp("mask", 24'h008000, {8'h00, mask});
    step;
    cmp("rx_on", 24'h000001, {23'h0, rx_on});
    rmx_host_inst.wr(12'h00E, 8'h5A);
    rdchk(12'h00F, 8'h80);
    for (k = 0; k < 2; k++) begin
      step;
      st = 2'(1 << k);
      step;
      st = 2'b00;
      cmp("rx_on", 24'h000000, {23'h0, rx_on});
      pulse(24'(2 << k));
      exp_p = set_p(exp_p, 24'(2 << k));
      step;
      cmp("rx_on", 24'h000001, {23'h0, rx_on});
    end
    rmx_host_inst.wr(12'h00F, 8'h00);
    rmx_host_inst.wr(12'h00E, 8'h00);
    exp_p = set_p(exp_p, 24'h000080);
    step;
    cmp("rx_on", 24'h000000, {23'h0, rx_on});
    cmp("pend", exp_p, pend);
    $display("test mask done");
    repeat (40) begin
      e = 24'($urandom);
      pulse(e);
      exp_p = set_p(exp_p, e);
      cmp("pend", exp_p, pend);
      k = $urandom_range(2);
      b = 8'($urandom);
      rmx_host_inst.wr(12'h010 + 12'(k), b);
      exp_p = clr_p(exp_p, k, b);
      rdchk(12'h010 + 12'(k), 8'(exp_p >> (8 * k)));
    end
    $display("test random done");
    pulse(24'hFFFFFF);
    exp_p = 24'h7FFFFF;
    rmx_host_inst.wr(12'h012, 8'hFF);
    cmp("pend", exp_p, pend);
    fork
      rmx_host_inst.wr(12'h011, 8'h00);
      pulse(24'h000100);
    join
    cmp("pend", 24'h7F0100 | (exp_p & 24'h0000FF), pend);
    rmx_host_inst.wr(12'h011, 8'h00);
    cmp("pend", 24'h7F00FF, pend);
    fork
      rmx_host_inst.wr(12'h010, 8'h00);
      pulse(24'h000001);
    join
    cmp("pend", 24'h7F0001, pend);
    $display("test collision done");
    final_report;
  end
endmodule : test_rx_mask_and_exception_flags
